// >>> verilog/crs_cfg.svh
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ------------------------------------------------------------------
// special-function addresses
// ------------------------------------------------------------------
`define CRS_ADDR_STACK_PTR_LOW  8'h81
`define CRS_ADDR_STACK_PTR_HIGH 8'h9b
`define CRS_ADDR_ACTIVITY       8'hc5
`define CRS_ADDR_FLAGS          8'hd0
`define CRS_ADDR_MAIN           8'he0
`define CRS_ADDR_AUX            8'hf0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CRS_RST_BYTE            8'h00

// ------------------------------------------------------------------
// flag word field positions
// ------------------------------------------------------------------
`define CRS_FLG_CARRY           7
`define CRS_FLG_HALF            6
`define CRS_FLG_USER            5
`define CRS_FLG_BANK_HI         4
`define CRS_FLG_BANK_LO         3
`define CRS_FLG_RANGE           2
`define CRS_FLG_SPARE           1
`define CRS_FLG_PARITY          0

// ------------------------------------------------------------------
// activity word field positions
// ------------------------------------------------------------------
`define CRS_ACT_HIGH_PRIO       6
`define CRS_ACT_LOW_PRIO        5
`define CRS_ACT_U1_TX           3
`define CRS_ACT_U1_RX           2
`define CRS_ACT_U0_TX           1
`define CRS_ACT_U0_RX           0

// ------------------------------------------------------------------
// address mode and stack arithmetic
// ------------------------------------------------------------------
`define CRS_AM_EXT_BIT          1
`define CRS_STACK_STEP          8'h01
`define CRS_BANK_SHIFT          3

`endif

// >>> verilog/crs_pkg.sv
`default_nettype none

package crs_pkg;

    // activity inputs from interrupt and uart logic
    typedef struct packed {
        logic high_prio_active;
        logic low_prio_active;
        logic uart1_tx_active;
        logic uart1_rx_active;
        logic uart0_tx_active;
        logic uart0_rx_active;
    } crs_activity_t;

    // special-function access from the cpu
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crs_sfr_req_t;

    // core datapath update of operand and flags
    typedef struct packed {
        logic       main_we;
        logic [7:0] main_val;
        logic       aux_we;
        logic [7:0] aux_val;
        logic       flags_we;
        logic [7:0] flags_val;
    } crs_core_upd_t;

    // stack operation request
    typedef struct packed {
        logic       push;
        logic       pop;
        logic [7:0] push_data;
    } crs_stack_req_t;

    // internal ram port
    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } crs_ram_req_t;

    typedef enum logic [1:0] {
        CRS_POP_IDLE = 2'b01,
        CRS_POP_WAIT = 2'b10
    } crs_pop_state_t;

endpackage

`default_nettype wire

// >>> verilog/crs_byte_ram.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// internal data ram with registered read data
// ------------------------------------------------------------------
module crs_byte_ram #(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              we,
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    output var  logic [7:0]        rdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    initial begin
        if (ADDR_W < 8 || ADDR_W > 16) begin
            $error("crs_byte_ram: ADDR_W out of range");
        end
    end

    // write port
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge sys_clk) begin
        if (re) begin
            rdata <= mem[addr];
        end
    end
endmodule

`default_nettype wire

// >>> verilog/crs_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"

module crs_core_regs #(
    parameter int RAM_ADDR_W = 16
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire crs_pkg::crs_sfr_req_t sfr_req,
    input  wire logic                  bit_we,
    input  wire logic [2:0]            bit_idx,
    input  wire logic                  bit_val,
    input  wire crs_pkg::crs_core_upd_t core_upd,
    input  wire crs_pkg::crs_stack_req_t stack_req,
    input  wire crs_pkg::crs_activity_t activity_in,
    input  wire logic [1:0]            addr_mode_bits,
    input  wire logic [2:0]            work_reg_idx,
    output logic [7:0]                 sfr_rdata,
    output logic [7:0]                 main_operand_reg,
    output logic [7:0]                 aux_operand,
    output logic [7:0]                 program_flags,
    output logic [7:0]                 stack_ptr_low,
    output logic [7:0]                 stack_ptr_high,
    output logic [7:0]                 activity_status,
    output logic [7:0]                 work_reg_addr,
    output logic [15:0]                stack_addr,
    output logic                       ext_mode,
    output logic                       pop_valid,
    output logic [7:0]                 pop_data
);
    import crs_pkg::*;

    initial begin
        if (RAM_ADDR_W != 16) begin
            $error("crs_core_regs: RAM_ADDR_W must be 16");
        end
    end

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    logic           wr_main;
    logic           wr_aux;
    logic           wr_flags;
    logic           wr_sp;
    logic           wr_esp;
    logic [7:0]     next_main;
    logic [7:0]     next_aux;
    logic [7:0]     next_flags;
    logic [7:0]     sp_plus;
    logic [15:0]    push_addr;
    logic [15:0]    pop_addr;
    logic [7:0]     ram_rdata;
    crs_ram_req_t   ram_req;
    crs_pop_state_t pop_state;

    // sfr write strobes per register
    assign wr_main  = sfr_req.wr && sfr_req.addr == `CRS_ADDR_MAIN;
    assign wr_aux   = sfr_req.wr && sfr_req.addr == `CRS_ADDR_AUX;
    assign wr_flags = sfr_req.wr && sfr_req.addr == `CRS_ADDR_FLAGS;
    assign wr_sp    = sfr_req.wr && sfr_req.addr == `CRS_ADDR_STACK_PTR_LOW;
    assign wr_esp   = sfr_req.wr && sfr_req.addr == `CRS_ADDR_STACK_PTR_HIGH;

    // ------------------------------------------------------------------
    // operand registers
    // ------------------------------------------------------------------
    // main operand: datapath update, sfr byte, bit write, then pop data
    always_comb begin
        next_main = main_operand_reg;
        if (core_upd.main_we) begin
            next_main = core_upd.main_val;
        end
        if (wr_main) begin
            next_main = sfr_req.wdata;
        end
        if (bit_we && sfr_req.addr == `CRS_ADDR_MAIN) begin
            next_main[bit_idx] = bit_val;
        end
        if (pop_valid && pop_state == CRS_POP_WAIT) begin
            next_main = ram_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            main_operand_reg <= `CRS_RST_BYTE;
        end else begin
            main_operand_reg <= next_main;
        end
    end

    // auxiliary operand
    always_comb begin
        next_aux = aux_operand;
        if (core_upd.aux_we) begin
            next_aux = core_upd.aux_val;
        end
        if (wr_aux) begin
            next_aux = sfr_req.wdata;
        end
        if (bit_we && sfr_req.addr == `CRS_ADDR_AUX) begin
            next_aux[bit_idx] = bit_val;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aux_operand <= `CRS_RST_BYTE;
        end else begin
            aux_operand <= next_aux;
        end
    end

    // ------------------------------------------------------------------
    // flag word
    // ------------------------------------------------------------------
    // parity always tracks the next main operand value
    always_comb begin
        next_flags = program_flags;
        if (core_upd.flags_we) begin
            next_flags = core_upd.flags_val;
        end
        if (wr_flags) begin
            next_flags = sfr_req.wdata;
        end
        if (bit_we && sfr_req.addr == `CRS_ADDR_FLAGS) begin
            next_flags[bit_idx] = bit_val;
        end
        next_flags[`CRS_FLG_PARITY] = ^next_main;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            program_flags <= `CRS_RST_BYTE;
        end else begin
            program_flags <= next_flags;
        end
    end

    // working register address from bank select
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            work_reg_addr <= `CRS_RST_BYTE;
        end else begin
            work_reg_addr <= {3'h0, next_flags[`CRS_FLG_BANK_HI:`CRS_FLG_BANK_LO],
                              work_reg_idx};
        end
    end

    // ------------------------------------------------------------------
    // stack pointer and extension
    // ------------------------------------------------------------------
    assign sp_plus   = stack_ptr_low + `CRS_STACK_STEP;
    assign push_addr = ext_mode ? {stack_ptr_high, sp_plus} : {8'h00, sp_plus};
    assign pop_addr  = ext_mode ? {stack_ptr_high, stack_ptr_low}
                                : {8'h00, stack_ptr_low};

    // push pre-increments, pop post-decrements
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            stack_ptr_low <= `CRS_RST_BYTE;
        end else if (wr_sp) begin
            stack_ptr_low <= sfr_req.wdata;
        end else if (stack_req.push) begin
            stack_ptr_low <= sp_plus;
        end else if (stack_req.pop && pop_state == CRS_POP_IDLE) begin
            stack_ptr_low <= stack_ptr_low - `CRS_STACK_STEP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            stack_ptr_high <= `CRS_RST_BYTE;
        end else if (wr_esp) begin
            stack_ptr_high <= sfr_req.wdata;
        end
    end

    // extended mode flag and stack address
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ext_mode   <= 1'b0;
            stack_addr <= 16'h0000;
        end else begin
            ext_mode   <= addr_mode_bits[`CRS_AM_EXT_BIT];
            stack_addr <= pop_addr;
        end
    end

    // ------------------------------------------------------------------
    // stack ram access
    // ------------------------------------------------------------------
    always_comb begin
        ram_req       = '0;
        ram_req.addr  = stack_req.push ? push_addr : pop_addr;
        ram_req.we    = stack_req.push;
        ram_req.wdata = stack_req.push_data;
        ram_req.re    = stack_req.pop && !stack_req.push && pop_state == CRS_POP_IDLE;
    end

    crs_byte_ram #(
        .ADDR_W (RAM_ADDR_W)
    ) u_ram (
        .sys_clk (sys_clk),
        .we      (ram_req.we),
        .re      (ram_req.re),
        .addr    (ram_req.addr),
        .wdata   (ram_req.wdata),
        .rdata   (ram_rdata)
    );

    // pop takes one cycle for the ram read
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pop_state <= CRS_POP_IDLE;
        end else begin
            case (pop_state)
                CRS_POP_IDLE: begin
                    if (ram_req.re) begin
                        pop_state <= CRS_POP_WAIT;
                    end
                end
                CRS_POP_WAIT: begin
                    pop_state <= CRS_POP_IDLE;
                end
                default: begin
                    pop_state <= CRS_POP_IDLE;
                end
            endcase
        end
    end

    // pop result presented with strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pop_valid <= 1'b0;
        end else begin
            pop_valid <= ram_req.re;
        end
    end

    assign pop_data = ram_rdata;

    // ------------------------------------------------------------------
    // activity word, read only
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            activity_status <= `CRS_RST_BYTE;
        end else begin
            activity_status <= 8'h00;
            activity_status[`CRS_ACT_HIGH_PRIO] <= activity_in.high_prio_active;
            activity_status[`CRS_ACT_LOW_PRIO]  <= activity_in.low_prio_active;
            activity_status[`CRS_ACT_U1_TX]     <= activity_in.uart1_tx_active;
            activity_status[`CRS_ACT_U1_RX]     <= activity_in.uart1_rx_active;
            activity_status[`CRS_ACT_U0_TX]     <= activity_in.uart0_tx_active;
            activity_status[`CRS_ACT_U0_RX]     <= activity_in.uart0_rx_active;
        end
    end

    // ------------------------------------------------------------------
    // sfr read mux, registered
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sfr_rdata <= `CRS_RST_BYTE;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                `CRS_ADDR_MAIN:           sfr_rdata <= main_operand_reg;
                `CRS_ADDR_AUX:            sfr_rdata <= aux_operand;
                `CRS_ADDR_FLAGS:          sfr_rdata <= program_flags;
                `CRS_ADDR_STACK_PTR_LOW:  sfr_rdata <= stack_ptr_low;
                `CRS_ADDR_STACK_PTR_HIGH: sfr_rdata <= stack_ptr_high;
                `CRS_ADDR_ACTIVITY:       sfr_rdata <= activity_status;
                default:                  sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> verification/crs_core_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"

// ------------------------------------------------------------------
// checker on the core register set ports
// ------------------------------------------------------------------
module crs_core_regs_props (
    input wire logic                     sys_clk,
    input wire logic                     resetn,
    input wire crs_pkg::crs_sfr_req_t    sfr_req,
    input wire logic                     bit_we,
    input wire logic [2:0]               bit_idx,
    input wire logic                     bit_val,
    input wire crs_pkg::crs_core_upd_t   core_upd,
    input wire crs_pkg::crs_stack_req_t  stack_req,
    input wire crs_pkg::crs_activity_t   activity_in,
    input wire logic [1:0]               addr_mode_bits,
    input wire logic [2:0]               work_reg_idx,
    input wire logic [7:0]               sfr_rdata,
    input wire logic [7:0]               main_operand_reg,
    input wire logic [7:0]               aux_operand,
    input wire logic [7:0]               program_flags,
    input wire logic [7:0]               stack_ptr_low,
    input wire logic [7:0]               stack_ptr_high,
    input wire logic [7:0]               activity_status,
    input wire logic [7:0]               work_reg_addr,
    input wire logic [15:0]              stack_addr,
    input wire logic                     ext_mode,
    input wire logic                     pop_valid,
    input wire logic [7:0]               pop_data
);
    import crs_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // byte writes over the special-function path
    property p_wr_main;
        sfr_req.wr && sfr_req.addr == `CRS_ADDR_MAIN && !bit_we && !pop_valid
        |=> main_operand_reg == $past(sfr_req.wdata);
    endproperty
    a_wr_main: assert property (p_wr_main) else $error("main operand write lost");
    property p_wr_aux;
        sfr_req.wr && sfr_req.addr == `CRS_ADDR_AUX && !bit_we
        |=> aux_operand == $past(sfr_req.wdata);
    endproperty
    a_wr_aux: assert property (p_wr_aux) else $error("aux operand write lost");
    property p_wr_flags;
        sfr_req.wr && sfr_req.addr == `CRS_ADDR_FLAGS && !bit_we
        |=> program_flags[7:1] == $past(sfr_req.wdata[7:1]);
    endproperty
    a_wr_flags: assert property (p_wr_flags) else $error("flag word write lost");
    property p_wr_high;
        sfr_req.wr && sfr_req.addr == `CRS_ADDR_STACK_PTR_HIGH
        |=> stack_ptr_high == $past(sfr_req.wdata);
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("stack high write lost");
    // parity always follows the main operand
    property p_parity;
        program_flags[0] == ^main_operand_reg;
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    // stack pointer movement and pop handshake
    property p_push;
        stack_req.push && !(sfr_req.wr && sfr_req.addr == `CRS_ADDR_STACK_PTR_LOW)
        |=> stack_ptr_low == $past(stack_ptr_low) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push did not step pointer");
    property p_pop;
        stack_req.pop && !stack_req.push && !pop_valid |=> pop_valid ##1 !pop_valid;
    endproperty
    a_pop: assert property (p_pop) else $error("pop answer missing");
    property p_pop_load;
        pop_valid |=> main_operand_reg == $past(pop_data);
    endproperty
    a_pop_load: assert property (p_pop_load) else $error("pop data not loaded");
    // activity word tracks its sources one cycle late
    property p_act_irq;
        $past(resetn) |-> activity_status[6:5] == $past(activity_in[5:4]);
    endproperty
    a_act_irq: assert property (p_act_irq) else $error("interrupt activity wrong");
    property p_act_uart;
        $past(resetn) |-> activity_status[3:0] == $past(activity_in[3:0]);
    endproperty
    a_act_uart: assert property (p_act_uart) else $error("uart activity wrong");
    property p_act_spare;
        activity_status[7] == 1'b0 && activity_status[4] == 1'b0;
    endproperty
    a_act_spare: assert property (p_act_spare) else $error("activity spare bit set");
    property p_ext;
        $past(resetn) |-> ext_mode == $past(addr_mode_bits[1]);
    endproperty
    a_ext: assert property (p_ext) else $error("extended mode wrong");
    property p_bank;
        $past(resetn) |-> work_reg_addr == {3'b000, program_flags[4:3], $past(work_reg_idx)};
    endproperty
    a_bank: assert property (p_bank) else $error("working register address wrong");

    c_pop: cover property (pop_valid);
    c_ext_push: cover property (stack_req.push && ext_mode);
    c_act_wr: cover property (sfr_req.wr && sfr_req.addr == `CRS_ADDR_ACTIVITY);
endmodule

bind crs_core_regs crs_core_regs_props u_crs_core_regs_props (
    .sys_clk, .resetn, .sfr_req, .bit_we, .bit_idx, .bit_val, .core_upd, .stack_req,
    .activity_in, .addr_mode_bits, .work_reg_idx, .sfr_rdata, .main_operand_reg,
    .aux_operand, .program_flags, .stack_ptr_low, .stack_ptr_high, .activity_status,
    .work_reg_addr, .stack_addr, .ext_mode, .pop_valid, .pop_data);

`default_nettype wire

// >>> verification/crs_core_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"

module crs_core_regs_tb;
    import crs_pkg::*;

    logic           sys_clk;
    logic           resetn;
    crs_sfr_req_t   sfr_req;
    logic           bit_we;
    logic [2:0]     bit_idx;
    logic           bit_val;
    crs_core_upd_t  core_upd;
    crs_stack_req_t stack_req;
    crs_activity_t  activity_in;
    logic [1:0]     addr_mode_bits;
    logic [2:0]     work_reg_idx;
    logic [7:0]     sfr_rdata, main_operand_reg, aux_operand, program_flags;
    logic [7:0]     stack_ptr_low, stack_ptr_high, activity_status, work_reg_addr;
    logic [7:0]     pop_data;
    logic [15:0]    stack_addr;
    logic           ext_mode, pop_valid;
    int             err_total, compares;

    crs_core_regs u_crs_core_regs (
        .sys_clk, .resetn, .sfr_req, .bit_we, .bit_idx, .bit_val, .core_upd, .stack_req,
        .activity_in, .addr_mode_bits, .work_reg_idx, .sfr_rdata, .main_operand_reg,
        .aux_operand, .program_flags, .stack_ptr_low, .stack_ptr_high, .activity_status,
        .work_reg_addr, .stack_addr, .ext_mode, .pop_valid, .pop_data);

    // ------------------------------------------------------------------
    // clock, compare and bus helpers
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle byte write, then a quiet cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        sfr_req = '0;
        @(negedge sys_clk);
    endtask

    // read data lands one cycle after the request
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        sfr_req = '0;
        chk(16'(sfr_rdata), 16'(e));
        @(negedge sys_clk);
    endtask

    task automatic bwr(input logic [7:0] a, input logic [2:0] i, input logic v);
        sfr_req = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 8'h00};
        bit_we = 1'b1;
        bit_idx = i;
        bit_val = v;
        @(negedge sys_clk);
        sfr_req = '0;
        bit_we = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic push(input logic [7:0] d);
        stack_req = '{push: 1'b1, pop: 1'b0, push_data: d};
        @(negedge sys_clk);
        stack_req = '0;
        @(negedge sys_clk);
    endtask

    // pop answer stands one cycle, main is loaded the edge after
    task automatic pop(input logic [7:0] e);
        stack_req = '{push: 1'b0, pop: 1'b1, push_data: 8'h00};
        @(negedge sys_clk);
        stack_req = '0;
        chk(16'(pop_valid), 16'h0001);
        chk(16'(pop_data), 16'(e));
        @(negedge sys_clk);
        chk(16'(main_operand_reg), 16'(e));
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] addrs [6] = '{`CRS_ADDR_MAIN, `CRS_ADDR_AUX, `CRS_ADDR_FLAGS,
                                  `CRS_ADDR_STACK_PTR_LOW, `CRS_ADDR_STACK_PTR_HIGH,
                                  `CRS_ADDR_ACTIVITY};
        foreach (addrs[i]) rd(addrs[i], `CRS_RST_BYTE);
        chk({main_operand_reg, stack_ptr_high}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_rw;
        wr(`CRS_ADDR_MAIN, 8'ha5);
        wr(`CRS_ADDR_AUX, 8'h5a);
        wr(`CRS_ADDR_STACK_PTR_HIGH, 8'hc3);
        wr(`CRS_ADDR_STACK_PTR_LOW, 8'h3c);
        wr(`CRS_ADDR_FLAGS, 8'hff);
        wr(`CRS_ADDR_ACTIVITY, 8'hff);
        rd(`CRS_ADDR_MAIN, 8'ha5);
        rd(`CRS_ADDR_AUX, 8'h5a);
        rd(`CRS_ADDR_STACK_PTR_HIGH, 8'hc3);
        rd(`CRS_ADDR_FLAGS, 8'hfe);
        rd(`CRS_ADDR_ACTIVITY, 8'h00);
        rd(`CRS_ADDR_STACK_PTR_LOW, 8'h3c);
        rd(8'h80, 8'h00);
        $display("test byte access done");
    endtask

    task automatic t_bits;
        bwr(`CRS_ADDR_MAIN, 3'd1, 1'b1);
        chk({main_operand_reg, program_flags}, 16'ha7ff);
        bwr(`CRS_ADDR_AUX, 3'd0, 1'b1);
        chk(16'(aux_operand), 16'h005b);
        bwr(`CRS_ADDR_FLAGS, 3'd5, 1'b0);
        chk(16'(program_flags), 16'h00df);
        core_upd = '{main_we: 1'b1, main_val: 8'h01, aux_we: 1'b1, aux_val: 8'h3c,
                     flags_we: 1'b1, flags_val: 8'h80};
        @(negedge sys_clk);
        core_upd = '0;
        chk({main_operand_reg, program_flags}, 16'h0181);
        chk(16'(aux_operand), 16'h003c);
        $display("test bit and datapath done");
    endtask

    task automatic t_bank;
        work_reg_idx = 3'd5;
        for (int b = 0; b < 4; b++) begin
            wr(`CRS_ADDR_FLAGS, 8'(b << 3));
            chk(16'(work_reg_addr), 16'((b << 3) | 5));
        end
        $display("test bank select done");
    endtask

    task automatic t_act;
        logic [7:0] e;
        for (int i = 0; i < 6; i++) begin
            activity_in = crs_activity_t'(6'(1 << i));
            e = (i < 4) ? 8'(1 << i) : 8'(1 << (i + 1));
            @(negedge sys_clk);
            rd(`CRS_ADDR_ACTIVITY, e);
        end
        activity_in = crs_activity_t'(6'h3f);
        wr(`CRS_ADDR_ACTIVITY, 8'h00);
        chk(16'(activity_status), 16'h006f);
        activity_in = '0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        chk(16'(activity_status), 16'h0000);
        $display("test activity done");
    endtask

    task automatic t_stack;
        addr_mode_bits = 2'b10;
        wr(`CRS_ADDR_STACK_PTR_HIGH, 8'h12);
        wr(`CRS_ADDR_STACK_PTR_LOW, 8'h40);
        push(8'h77);
        chk(16'(stack_ptr_low), 16'h0041);
        chk({15'h0000, ext_mode}, 16'h0001);
        chk(stack_addr, 16'h1241);
        addr_mode_bits = 2'b00;
        wr(`CRS_ADDR_STACK_PTR_LOW, 8'h40);
        chk(stack_addr, 16'h0040);
        push(8'h99);
        addr_mode_bits = 2'b11;
        @(negedge sys_clk);
        pop(8'h77);
        chk(16'(stack_ptr_low), 16'h0040);
        wr(`CRS_ADDR_STACK_PTR_LOW, 8'h41);
        addr_mode_bits = 2'b01;
        @(negedge sys_clk);
        pop(8'h99);
        $display("test stack done");
    endtask

    task automatic t_rerst;
        resetn = 1'b0;
        @(negedge sys_clk);
        resetn = 1'b1;
        chk({main_operand_reg, stack_ptr_high}, 16'h0000);
        chk({program_flags, stack_ptr_low}, 16'h0000);
        $display("test second reset done");
    endtask

    // ------------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        test_done;
    end

    initial begin
        resetn = 1'b0;
        sfr_req = '0;
        bit_we = 1'b0;
        bit_idx = 3'd0;
        bit_val = 1'b0;
        core_upd = '0;
        stack_req = '0;
        activity_in = '0;
        addr_mode_bits = 2'b00;
        work_reg_idx = 3'd0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        t_reset;
        t_rw;
        t_bits;
        t_bank;
        t_act;
        t_stack;
        t_rerst;
        test_done;
    end
endmodule

`default_nettype wire
